// ---- process_regulator_feedback.sv ----
// Feedback combination and PID regulator with APB register access
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module process_regulator_feedback #(
  parameter int SAMPLE_CYCLES = process_regulator_pkg::SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [process_regulator_pkg::AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] ain1,
  input wire logic [15:0] ain2,
  input wire logic run_cmd,
  input wire logic cur_limit,
  input wire logic volt_limit,
  output logic [15:0] freq_demand,
  output logic regulator_active,
  output logic [15:0] feedback_value
);
  localparam int DW = process_regulator_pkg::DW;
  localparam int SW = 35;
  typedef enum {ST_IDLE, ST_START, ST_ROOT, ST_FILT, ST_REG} state_type;

  // **********************************************************
  // Registers
  // **********************************************************
  logic [7:0] ctrl_r;
  logic signed [DW-1:0] sp1_r, sp2_r, bus1_r, bus2_r, rem_r;
  logic [DW-1:0] kp_r, ki_r, kd_r, dcap_r, tau_r, fmin_r, fmax_r, start_r;
  logic ctrl_written_r;
  logic wr_en, rd_setup, mapped;
  logic [31:0] rd_mux;
  logic signed [DW-1:0] freq_r;
  logic active_r, hold_r, hold_neg_r, limit_r, startup_r, run_d_r, at_clamp;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      process_regulator_pkg::CTRL_OFS: rd_mux = 32'(ctrl_r);
      process_regulator_pkg::SETPT1_OFS: rd_mux = 32'(sp1_r);
      process_regulator_pkg::SETPT2_OFS: rd_mux = 32'(sp2_r);
      process_regulator_pkg::BUSFB1_OFS: rd_mux = 32'(bus1_r);
      process_regulator_pkg::BUSFB2_OFS: rd_mux = 32'(bus2_r);
      process_regulator_pkg::REMREF_OFS: rd_mux = 32'(rem_r);
      process_regulator_pkg::PGAIN_OFS: rd_mux = 32'(kp_r);
      process_regulator_pkg::IGAIN_OFS: rd_mux = 32'(ki_r);
      process_regulator_pkg::DGAIN_OFS: rd_mux = 32'(kd_r);
      process_regulator_pkg::DCAP_OFS: rd_mux = 32'(dcap_r);
      process_regulator_pkg::FILT_OFS: rd_mux = 32'(tau_r);
      process_regulator_pkg::FMIN_OFS: rd_mux = 32'(fmin_r);
      process_regulator_pkg::FMAX_OFS: rd_mux = 32'(fmax_r);
      process_regulator_pkg::START_OFS: rd_mux = 32'(start_r);
      process_regulator_pkg::STATUS_OFS: rd_mux = {28'h0, startup_r, hold_r, limit_r, active_r};
      process_regulator_pkg::FBVAL_OFS: rd_mux = 32'(feedback_value);
      process_regulator_pkg::FREQ_OFS: rd_mux = 32'(freq_r);
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Stored values are 16 bits, control 8 bits; upper write data is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= process_regulator_pkg::CTRL_RST;
      ctrl_written_r <= 1'b0;
      {sp1_r, sp2_r, bus1_r, bus2_r, rem_r} <= '0;
      kp_r <= process_regulator_pkg::PGAIN_RST;
      {ki_r, kd_r, fmin_r, start_r} <= '0;
      dcap_r <= process_regulator_pkg::DCAP_RST;
      tau_r <= process_regulator_pkg::FILT_RST;
      fmax_r <= process_regulator_pkg::FMAX_RST;
    end else if (wr_en) begin
      case (paddr)
        process_regulator_pkg::CTRL_OFS: begin
          ctrl_r <= pwdata[7:0];
          ctrl_written_r <= 1'b1;
        end
        process_regulator_pkg::SETPT1_OFS: sp1_r <= pwdata[DW-1:0];
        process_regulator_pkg::SETPT2_OFS: sp2_r <= pwdata[DW-1:0];
        process_regulator_pkg::BUSFB1_OFS: bus1_r <= pwdata[DW-1:0];
        process_regulator_pkg::BUSFB2_OFS: bus2_r <= pwdata[DW-1:0];
        process_regulator_pkg::REMREF_OFS: rem_r <= pwdata[DW-1:0];
        process_regulator_pkg::PGAIN_OFS: kp_r <= pwdata[DW-1:0];
        process_regulator_pkg::IGAIN_OFS: ki_r <= pwdata[DW-1:0];
        process_regulator_pkg::DGAIN_OFS: kd_r <= pwdata[DW-1:0];
        process_regulator_pkg::DCAP_OFS: dcap_r <= pwdata[DW-1:0];
        process_regulator_pkg::FILT_OFS: tau_r <= pwdata[DW-1:0];
        process_regulator_pkg::FMIN_OFS: fmin_r <= pwdata[DW-1:0];
        process_regulator_pkg::FMAX_OFS: fmax_r <= pwdata[DW-1:0];
        process_regulator_pkg::START_OFS: start_r <= pwdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // **********************************************************
  // Pin synchronisers and sample timer
  // **********************************************************
  logic [SW-1:0] sync1_r, sync2_r;
  logic signed [DW-1:0] ain1_s, ain2_s;
  logic run_s, lim_s;
  logic [31:0] tick_cnt_r;
  logic tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {ain1, ain2, run_cmd, cur_limit, volt_limit};
      sync2_r <= sync1_r;
    end
  end

  assign {ain1_s, ain2_s, run_s} = sync2_r[SW-1:2];
  assign lim_s = sync2_r[1] | sync2_r[0];
  assign tick = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // **********************************************************
  // Latched configuration and feedback combination
  // **********************************************************
  state_type state_r;
  logic [7:0] cfg_r;
  logic signed [DW-1:0] fb1_r, fb2_r, ref_r;
  logic [DW-1:0] kp_l, ki_l, kd_l, dcap_l, fmin_l, fmax_l, start_l;
  logic signed [DW+1:0] comb;
  logic signed [DW-1:0] comb_sat, fb_conv, fb_filt;
  logic [3:0] cmb;
  logic [process_regulator_pkg::ROOT_N-1:0] root;
  logic root_busy;

  assign cmb = cfg_r[process_regulator_pkg::CMB_LSB +: process_regulator_pkg::CMB_W];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= process_regulator_pkg::CTRL_RST;
      {fb1_r, fb2_r, ref_r} <= '0;
      {kp_l, ki_l, kd_l, dcap_l, fmin_l, fmax_l, start_l} <= '0;
    end else if (state_r == ST_IDLE && tick) begin
      cfg_r <= ctrl_r;
      fb1_r <= bus1_r + ain1_s;
      fb2_r <= bus2_r + ain2_s;
      // Setpoint two only with channel two alone
      ref_r <= rem_r + ((ctrl_r[7:4] == process_regulator_pkg::CMB_FB2) ? sp2_r : sp1_r);
      {kp_l, ki_l, kd_l, dcap_l} <= {kp_r, ki_r, kd_r, dcap_r};
      {fmin_l, fmax_l, start_l} <= {fmin_r, fmax_r, start_r};
    end
  end

  // Codes 5, 6 and the curve option fall back to channel one
  always_comb begin
    case (cmb)
      process_regulator_pkg::CMB_MIN: comb = (fb1_r < fb2_r) ? 18'(fb1_r) : 18'(fb2_r);
      process_regulator_pkg::CMB_MAX: comb = (fb1_r > fb2_r) ? 18'(fb1_r) : 18'(fb2_r);
      process_regulator_pkg::CMB_SUM: comb = 18'(fb1_r) + 18'(fb2_r);
      process_regulator_pkg::CMB_DIFF: comb = 18'(fb2_r) - 18'(fb1_r);
      process_regulator_pkg::CMB_AVG: comb = (18'(fb1_r) + 18'(fb2_r)) >>> 1;
      process_regulator_pkg::CMB_FB2: comb = 18'(fb2_r);
      default: comb = 18'(fb1_r);
    endcase
    if (comb > 18'sd32767) comb_sat = 16'sh7FFF;
    else if (comb < -18'sd32768) comb_sat = 16'sh8000;
    else comb_sat = comb[DW-1:0];
  end

  // Root starts a cycle after the latch so it sees this sample's feedback
  feedback_root #(.N(process_regulator_pkg::ROOT_N)) u_root (
    .clk(clk),
    .rst_n(rst_n),
    .start(state_r == ST_START),
    .radicand(comb_sat[DW-1] ? 24'h000000 : {comb_sat[15:0], 8'h00}),
    .root(root),
    .busy(root_busy)
  );

  // Root of x*256 keeps the value at sixteen times sqrt(x)
  assign fb_conv = cfg_r[process_regulator_pkg::CONV_BIT] ? DW'(root) : comb_sat;

  feedback_lowpass #(
    .DW(DW),
    .FRAC(process_regulator_pkg::FILT_FRAC),
    .TS_MS(process_regulator_pkg::SAMPLE_TIME_MS)
  ) u_lowpass (
    .clk(clk),
    .rst_n(rst_n),
    .update(state_r == ST_FILT),
    .sample(fb_conv),
    .tau_ms(tau_r),
    .smooth(fb_filt)
  );

  // Display value runs in both loop modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feedback_value <= '0;
    end else if (state_r == ST_REG) begin
      feedback_value <= fb_filt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (tick) state_r <= ST_START;
        ST_START: state_r <= ST_ROOT;
        ST_ROOT: if (!root_busy) state_r <= ST_FILT;
        ST_FILT: state_r <= ST_REG;
        ST_REG: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // **********************************************************
  // PID regulator
  // **********************************************************
  logic signed [31:0] err, p_term, i_nxt, d_raw, d_lim, d_term, raw, clamped;
  logic signed [31:0] integ_r, err_prev_r;

  always_comb begin
    err = cfg_r[process_regulator_pkg::DIR_BIT] ? 32'(fb_filt) - 32'(ref_r)
                                                : 32'(ref_r) - 32'(fb_filt);
    // Signed products so a negative error keeps its sign
    p_term = ($signed(32'(kp_l)) * err) >>> process_regulator_pkg::GAIN_FRAC;
    i_nxt = integ_r + (($signed(32'(ki_l)) * err) >>> process_regulator_pkg::GAIN_FRAC);
    d_raw = ($signed(32'(kd_l)) * (err - err_prev_r)) >>> process_regulator_pkg::GAIN_FRAC;
    d_lim = ($signed(32'(dcap_l)) * (err < 0 ? -err : err)) >>> process_regulator_pkg::CAP_FRAC;
    if (d_raw > d_lim) d_term = d_lim;
    else if (d_raw < -d_lim) d_term = -d_lim;
    else d_term = d_raw;
    raw = p_term + i_nxt + d_term;
    at_clamp = (raw >= $signed(32'(fmax_l))) || (raw <= $signed(32'(fmin_l)));
    if (raw > $signed(32'(fmax_l))) clamped = 32'(fmax_l);
    else if (raw < $signed(32'(fmin_l))) clamped = 32'(fmin_l);
    else clamped = raw;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {integ_r, err_prev_r} <= '0;
      freq_r <= '0;
      {active_r, hold_r, hold_neg_r, limit_r, startup_r, run_d_r} <= '0;
    end else if (state_r == ST_REG) begin
      run_d_r <= run_s;
      err_prev_r <= err;
      if (!run_s) begin
        freq_r <= '0;
        integ_r <= '0;
        {active_r, hold_r, startup_r, limit_r} <= '0;
      end else if (!cfg_r[process_regulator_pkg::LOOP_BIT]) begin
        // Open loop: feedback only displayed
        freq_r <= (ref_r < $signed(fmin_l)) ? fmin_l : (ref_r > $signed(fmax_l)) ? fmax_l : ref_r;
        {active_r, hold_r, startup_r} <= '0;
      end else if ((!run_d_r && start_l != '0) || startup_r) begin
        startup_r <= 1'b1;
        active_r <= 1'b0;
        if ($signed(freq_r) >= $signed(start_l)) begin
          startup_r <= 1'b0;
          active_r <= 1'b1;
          integ_r <= 32'(freq_r);
        end else begin
          freq_r <= freq_r + process_regulator_pkg::START_STEP;
        end
      end else if (hold_r) begin
        integ_r <= 32'(freq_r);
        if (err == 0 || (err < 0) != hold_neg_r) hold_r <= 1'b0;
      end else begin
        active_r <= 1'b1;
        limit_r <= at_clamp || lim_s;
        if (cfg_r[process_regulator_pkg::AWU_BIT] && (at_clamp || lim_s)) begin
          // A clamp still moves the output onto the limit it hit
          if (at_clamp) freq_r <= clamped[DW-1:0];
          integ_r <= at_clamp ? 32'($signed(clamped[DW-1:0])) : 32'(freq_r);
          hold_r <= 1'b1;
          hold_neg_r <= err < 0;
        end else begin
          integ_r <= i_nxt;
          freq_r <= clamped[DW-1:0];
        end
      end
    end
  end

  assign freq_demand = freq_r;
  assign regulator_active = active_r;

  // **********************************************************
  // Checks
  // **********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_awu_default: assert property (!ctrl_written_r |-> ctrl_r == process_regulator_pkg::CTRL_RST)
    else $error("control register lost its reset value");
  chk_sample_start: assert property (state_r == ST_IDLE && !tick |=> state_r == ST_IDLE)
    else $error("sample started without tick");
  chk_dcap_bound: assert property (state_r == ST_REG |-> d_term <= d_lim && d_term >= -d_lim)
    else $error("derivative exceeds cap");
  chk_freq_clamp: assert property (state_r == ST_REG && active_r && !hold_r
      |=> $signed(freq_r) <= $signed(fmax_l))
    else $error("frequency above maximum");
  chk_awu_reload: assert property (state_r == ST_REG && run_s && !hold_r
      && !startup_r && (run_d_r || start_l == '0) && cfg_r[process_regulator_pkg::LOOP_BIT]
      && cfg_r[process_regulator_pkg::AWU_BIT] && (lim_s || at_clamp)
      |=> hold_r && integ_r == 32'(freq_r))
    else $error("integrator not reloaded at limit");
  chk_hold_release: assert property (state_r == ST_REG && run_s && hold_r
      && !startup_r && cfg_r[process_regulator_pkg::LOOP_BIT] && err == 0 |=> !hold_r)
    else $error("hold not released at zero error");
  chk_startup_first: assert property (startup_r |-> !active_r)
    else $error("regulator engaged during start-up");
  chk_direction: assert property (state_r == ST_REG
      && !cfg_r[process_regulator_pkg::DIR_BIT] && ref_r > fb_filt |-> err > 0)
    else $error("error sign wrong in normal direction");
  chk_sqrt_feed: assert property (state_r == ST_FILT
      && cfg_r[process_regulator_pkg::CONV_BIT]
      |-> 32'(root) * 32'(root) <= 32'(comb_sat[DW-1] ? 16'h0000 : comb_sat) * 256
      && (32'(root) + 1) * (32'(root) + 1) > 32'(comb_sat[DW-1] ? 16'h0000 : comb_sat) * 256)
    else $error("root conversion wrong");
  chk_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not flagged");

  cov_hold: cover property (state_r == ST_REG ##1 $rose(hold_r));
  cov_startup_done: cover property ($fell(startup_r) ##0 active_r);
  cov_inverse: cover property (state_r == ST_REG && cfg_r[process_regulator_pkg::DIR_BIT] && active_r);
  cov_root: cover property (state_r == ST_FILT && cfg_r[process_regulator_pkg::CONV_BIT]);
endmodule : process_regulator_feedback

// ---- process_regulator_pkg.sv ----
// Constants, register map and timing for the process regulator
// Behaviour
// - Normal direction raises speed when reference exceeds feedback; inverse reverses it
// - Anti-windup on any limit reloads integrator with present output frequency
// - Anti-windup is on after reset and can be switched off
// - A programmed start-up frequency is reached before the regulator engages
// - Derivative contribution is capped by a programmable gain limit
// - Feedback passes a first-order lowpass with programmable time constant
// - Each feedback channel is bus feedback plus its analogue input
// - Conversion code 0 passes feedback, code 1 takes its square root
// - Combine code 0 uses the smaller feedback channel
// - Combine code 1 uses the larger feedback channel
// - Combine code 2 uses the sum, reference added to setpoint one
// - Combine code 3 uses channel two minus channel one
// - Combine code 4 uses the mean, reference added to setpoint one
// - Combine code 7 uses channel one only, against setpoint one
// - Combine code 8 uses channel two only, against setpoint two
// - Combine selector resets to code 9, the curve-based option
// - Reference is remote reference plus setpoint; error is reference minus feedback in normal direction
// - Added setpoint follows the selected combine code
// - Feedback processing runs in open and closed loop; open loop only displays
// - After a reload the regulator waits until error is zero or flips sign
package process_regulator_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam logic [AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] SETPT1_OFS = 8'h04;
  localparam logic [AW-1:0] SETPT2_OFS = 8'h08;
  localparam logic [AW-1:0] BUSFB1_OFS = 8'h0C;
  localparam logic [AW-1:0] BUSFB2_OFS = 8'h10;
  localparam logic [AW-1:0] REMREF_OFS = 8'h14;
  localparam logic [AW-1:0] PGAIN_OFS = 8'h18;
  localparam logic [AW-1:0] IGAIN_OFS = 8'h1C;
  localparam logic [AW-1:0] DGAIN_OFS = 8'h20;
  localparam logic [AW-1:0] DCAP_OFS = 8'h24;
  localparam logic [AW-1:0] FILT_OFS = 8'h28;
  localparam logic [AW-1:0] FMIN_OFS = 8'h2C;
  localparam logic [AW-1:0] FMAX_OFS = 8'h30;
  localparam logic [AW-1:0] START_OFS = 8'h34;
  localparam logic [AW-1:0] STATUS_OFS = 8'h38;
  localparam logic [AW-1:0] FBVAL_OFS = 8'h3C;
  localparam logic [AW-1:0] FREQ_OFS = 8'h40;
  // Control register fields
  localparam int CONV_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam int AWU_BIT = 2;
  localparam int LOOP_BIT = 3;
  localparam int CMB_LSB = 4;
  localparam int CMB_W = 4;
  localparam logic [7:0] CTRL_RST = 8'h94;
  // Combine codes
  localparam logic [3:0] CMB_MIN = 4'h0;
  localparam logic [3:0] CMB_MAX = 4'h1;
  localparam logic [3:0] CMB_SUM = 4'h2;
  localparam logic [3:0] CMB_DIFF = 4'h3;
  localparam logic [3:0] CMB_AVG = 4'h4;
  localparam logic [3:0] CMB_FB1 = 4'h7;
  localparam logic [3:0] CMB_FB2 = 4'h8;
  localparam logic [3:0] CMB_CURVE = 4'h9;
  // Reset values, gains Q8, cap Q4, frequency in 0.1 Hz
  localparam logic [DW-1:0] PGAIN_RST = 16'h0200;
  localparam logic [DW-1:0] DCAP_RST = 16'h0050;
  localparam logic [DW-1:0] FILT_RST = 16'h000A;
  localparam logic [DW-1:0] FMAX_RST = 16'h01F4;
  localparam int GAIN_FRAC = 8;
  localparam int CAP_FRAC = 4;
  localparam int FILT_FRAC = 8;
  localparam int ROOT_N = 12;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int SAMPLE_TIME_US = 1000;
  localparam int SAMPLE_CYCLES = SAMPLE_TIME_US * CLK_MHZ;
  localparam int SAMPLE_TIME_MS = SAMPLE_TIME_US / 1000;
  localparam logic [DW-1:0] START_STEP = 16'h0001;
endpackage : process_regulator_pkg

// ---- feedback_root.sv ----
// Sequential square root used for feedback conversion
`timescale 1ns/1ns
module feedback_root #(
  parameter int N = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2*N-1:0] radicand,
  output logic [N-1:0] root,
  output logic busy
);
  logic [2*N-1:0] rem_r;
  logic [2*N-1:0] res_r;
  logic [2*N-1:0] bit_r;

  // One result bit per clock, N clocks in all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= '0;
      res_r <= '0;
      bit_r <= '0;
    end else if (start) begin
      rem_r <= radicand;
      res_r <= '0;
      bit_r <= {2'b01, {(2*N-2){1'b0}}};
    end else if (bit_r != '0) begin
      if (rem_r >= res_r + bit_r) begin
        rem_r <= rem_r - (res_r + bit_r);
        res_r <= (res_r >> 1) + bit_r;
      end else begin
        res_r <= res_r >> 1;
      end
      bit_r <= bit_r >> 2;
    end
  end

  assign busy = (bit_r != '0);
  assign root = res_r[N-1:0];
endmodule : feedback_root

// ---- feedback_lowpass.sv ----
// First-order lowpass on the processed feedback
`timescale 1ns/1ns
module feedback_lowpass #(
  parameter int DW = 16,
  parameter int FRAC = 8,
  parameter int TS_MS = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic update,
  input wire logic signed [DW-1:0] sample,
  input wire logic [DW-1:0] tau_ms,
  output logic signed [DW-1:0] smooth
);
  logic signed [DW+FRAC-1:0] acc_r;
  logic signed [31:0] diff;
  logic signed [31:0] tau;

  // Step of (x - y) * Ts / tau gives corner at 1/tau rad/s
  always_comb begin
    diff = 32'(sample) * (32'sd1 <<< FRAC) - 32'(acc_r);
    tau = (tau_ms < 16'(TS_MS)) ? 32'sd1 * TS_MS : 32'(tau_ms);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else if (update) begin
      acc_r <= (DW+FRAC)'(32'(acc_r) + (diff * TS_MS) / tau);
    end
  end

  assign smooth = acc_r[DW+FRAC-1:FRAC];
endmodule : feedback_lowpass

// ---- process_plant_model.sv ----
// Model of the feedback transmitters and the motor output stage
`timescale 1ns/1ns
module process_plant_model (
  input wire logic [15:0] level1,
  input wire logic [15:0] level2,
  input wire logic [15:0] freq_demand,
  input wire logic [15:0] cur_ceiling,
  output logic [15:0] ain1,
  output logic [15:0] ain2,
  output logic cur_limit,
  output logic volt_limit
);
  // ****************************************
  // Transmitters and motor stage
  // ****************************************
  // Transmitter levels reach the analogue inputs unscaled
  assign ain1 = level1;
  assign ain2 = level2;
  // Motor stage reports current limit at or above a set demand
  assign cur_limit = $signed(freq_demand) >= $signed(cur_ceiling);
  assign volt_limit = 1'b0;
endmodule : process_plant_model

// ---- process_regulator_feedback_test.sv ----
// Self-checking bench for the process regulator feedback block
`timescale 1ns/1ns
module process_regulator_feedback_test;
  // Short sample period keeps the run brief
  localparam int SC = 64;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic run_cmd = 1'b0;
  logic [15:0] level1 = 16'h0014;
  logic [15:0] level2 = 16'h000A;
  logic [15:0] cur_ceiling = 16'h7FFF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, cur_limit, volt_limit, regulator_active, err;
  logic [15:0] ain1, ain2, freq_demand, feedback_value;
  int fail_count = 0;
  int num_checks = 0;
  logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8};
  // fb1 = 80 + 20, fb2 = 30 + 10
  logic [15:0] fbexp [7] = '{16'h0028, 16'h0064, 16'h008C, 16'hFFC4, 16'h0046, 16'h0064, 16'h0028};

  always #10 clk = ~clk;

  process_regulator_feedback #(.SAMPLE_CYCLES(SC)) process_regulator_feedback_inst (.clk, .rst_n,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ain1, .ain2,
    .run_cmd, .cur_limit, .volt_limit, .freq_demand, .regulator_active, .feedback_value);
  process_plant_model process_plant_model_inst (.level1, .level2, .freq_demand, .cur_ceiling,
    .ain1, .ain2, .cur_limit, .volt_limit);

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait state assumed: wait on pready itself
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h00000000, 32'h00000001);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rdchk

  task automatic samples(input int n);
    repeat (n * SC) @(posedge clk);
  endtask : samples

  initial begin
    repeat (200 * SC) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h00000094);
    rdchk(8'h18, 32'h00000200);
    rdchk(8'h24, 32'h00000050);
    rdchk(8'h28, 32'h0000000A);
    rdchk(8'h30, 32'h000001F4);
    rdchk(8'h80, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b1, 8'h40, 32'h00001234);
    rdchk(8'h40, 32'h00000000);
    apb(1'b1, 8'h0C, 32'h00000050);
    apb(1'b1, 8'h10, 32'h0000001E);
    apb(1'b1, 8'h28, 32'h00000001);
    apb(1'b1, 8'h04, 32'h00000032);
    apb(1'b1, 8'h08, 32'h000000C8);
    apb(1'b1, 8'h14, 32'h0000000A);
    run_cmd <= 1'b1;
    // Open loop: every combine code but the curve code 9, setpoint follows the code
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 8'h00, {24'h0, codes[i], 4'h0});
      samples(3);
      chk({16'h0, feedback_value}, {16'h0, fbexp[i]});
      rdchk(8'h3C, {16'h0, fbexp[i]});
      chk({16'h0, freq_demand}, (codes[i] == 4'h8) ? 32'h000000D2 : 32'h0000003C);
      chk({31'h0, regulator_active}, 32'h00000000);
    end
    apb(1'b1, 8'h00, 32'h00000071);
    samples(3);
    chk({16'h0, feedback_value}, 32'h000000A0);
    // Closed loop, anti-windup off so the direction swap cannot latch a hold
    apb(1'b1, 8'h04, 32'h00000096);
    apb(1'b1, 8'h00, 32'h00000078);
    samples(3);
    chk({16'h0, freq_demand}, 32'h00000078);
    chk({31'h0, regulator_active}, 32'h00000001);
    apb(1'b1, 8'h04, 32'h0000000A);
    apb(1'b1, 8'h00, 32'h0000007A);
    samples(3);
    chk({16'h0, freq_demand}, 32'h000000A0);
    // Clamp at maximum counts as a limit and holds the regulator
    apb(1'b1, 8'h30, 32'h00000064);
    apb(1'b1, 8'h04, 32'h00000096);
    apb(1'b1, 8'h00, 32'h0000007C);
    run_cmd <= 1'b0;
    samples(2);
    chk({16'h0, freq_demand}, 32'h00000000);
    run_cmd <= 1'b1;
    samples(3);
    chk({16'h0, freq_demand}, 32'h00000064);
    apb(1'b0, 8'h38, 32'h00000000);
    chk({30'h0, rd[2:1]}, 32'h00000003);
    // Zero error releases the hold
    apb(1'b1, 8'h30, 32'h000001F4);
    apb(1'b1, 8'h04, 32'h0000005A);
    samples(3);
    chk({16'h0, freq_demand}, 32'h00000064);
    apb(1'b0, 8'h38, 32'h00000000);
    chk({30'h0, rd[2:1]}, 32'h00000000);
    // Current limit from the motor stage reloads and holds as well
    cur_ceiling <= 16'h0064;
    samples(3);
    chk({16'h0, freq_demand}, 32'h00000064);
    apb(1'b0, 8'h38, 32'h00000000);
    chk({31'h0, rd[1]}, 32'h00000001);
    cur_ceiling <= 16'h7FFF;
    // Start-up frequency is reached before the regulator engages
    run_cmd <= 1'b0;
    apb(1'b1, 8'h30, 32'h000001F4);
    apb(1'b1, 8'h34, 32'h00000005);
    samples(2);
    run_cmd <= 1'b1;
    samples(2);
    chk({31'h0, regulator_active}, 32'h00000000);
    samples(10);
    chk({31'h0, regulator_active}, 32'h00000001);
    chk({16'h0, freq_demand}, 32'h00000005);
    give_verdict();
  end
endmodule : process_regulator_feedback_test
